// [src/dcr_regs.sv]
// Device capability and device control register bank of one switch port.
`timescale 1ns/1ps
// How it works
// - Capability bits 2:0 code 128/256/512 bytes as 0/1/2, reset to 1.
// - Capability bits 4:3 always read zero.
// - Capability bit 5 always reads zero.
// - Capability bits 8:6 and 11:9 are read-only zero.
// - Capability bit 15 reads one by default.
// - An upstream port captures slot power value and scale, else zero.
// - Control bits 3:0 are read-write error enables that reset to zero.
// - Control bit 4 always reads zero.
// - Control bits 7:5 hold the programmed payload size, resetting to zero.
// - A written payload code above the supported code is stored as supported; a preloaded one is stored as given.
// - Control bits 8 and 9 always read zero whatever is written.
// - Control bit 10 is read-only zero.
// - Control bit 11 always reads zero.
// - Control bits 14:12 are hardwired to zero.
module dcr_regs (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic UPSTREAM,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [31:0] CFG_WDATA,
    input wire logic [3:0] CFG_BE,
    input wire logic PWR_MSG,
    input wire logic [7:0] PWR_MSG_VALUE,
    input wire logic [1:0] PWR_MSG_SCALE,
    input wire logic PRELOAD,
    input wire logic [2:0] PRELOAD_MPS_SUP,
    input wire logic PRELOAD_RBER,
    input wire logic [3:0] PRELOAD_ERR_EN,
    input wire logic [2:0] PRELOAD_MPS,
    output logic [31:0] CFG_RDATA,
    output logic CFG_RVALID,
    output logic [3:0] ERR_REPORT_EN,
    output logic [2:0] MAX_PAYLOAD
);
    // -------------------------------------------------------------------
    // Upstream strap synchronisation
    // -------------------------------------------------------------------
    logic up_sync;

    dcr_sync u_up_sync (
        .CLK(CLK),
        .RST(RST),
        .ce(CE),
        .din(UPSTREAM),
        .dout(up_sync)
    );

    // -------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------
    logic [2:0] mps_sup;
    logic rber;
    logic [7:0] pwr_val;
    logic [1:0] pwr_scl;
    logic [3:0] err_en;
    logic [2:0] mps;
    logic [31:0] rdata;
    logic rvalid;
    logic [2:0] next_mps_sup;
    logic next_rber;
    logic [7:0] next_pwr_val;
    logic [1:0] next_pwr_scl;
    logic [3:0] next_err_en;
    logic [2:0] next_mps;
    logic [31:0] next_rdata;
    logic next_rvalid;
    logic [31:0] cap_word;
    logic [31:0] ctl_word;
    logic [2:0] wr_mps;
    logic sel_ctl;

    always_comb
    begin
        cap_word = 32'h0;
        cap_word[dcr_pkg::MPS_SUP_LSB +: 3] = mps_sup;
        cap_word[dcr_pkg::RBER_BIT] = rber;
        cap_word[dcr_pkg::PWR_VAL_LSB +: 8] = pwr_val;
        cap_word[dcr_pkg::PWR_SCL_LSB +: 2] = pwr_scl;
        ctl_word = 32'h0;
        ctl_word[dcr_pkg::ERR_EN_LSB +: 4] = err_en;
        ctl_word[dcr_pkg::MPS_LSB +: 3] = mps;
    end

    always_comb
    begin
        next_mps_sup = mps_sup;
        next_rber = rber;
        next_pwr_val = pwr_val;
        next_pwr_scl = pwr_scl;
        next_err_en = err_en;
        next_mps = mps;
        next_rdata = rdata;
        next_rvalid = 1'h0;
        sel_ctl = CFG_ADDR == dcr_pkg::OFS_DEV_CTL;
        wr_mps = CFG_WDATA[dcr_pkg::MPS_LSB +: 3];
        if (wr_mps > mps_sup)
        begin
            wr_mps = mps_sup;
        end
        if (CE)
        begin
            if (PRELOAD)
            begin
                next_mps_sup = (PRELOAD_MPS_SUP > dcr_pkg::MPS_MAX_CODE)
                    ? dcr_pkg::MPS_MAX_CODE : PRELOAD_MPS_SUP;
                next_rber = PRELOAD_RBER;
                next_err_en = PRELOAD_ERR_EN;
                next_mps = PRELOAD_MPS;
            end
            // control writes, low byte lane for both fields
            else if (CFG_WR && sel_ctl)
            begin
                if (CFG_BE[0])
                begin
                    next_err_en = CFG_WDATA[dcr_pkg::ERR_EN_LSB +: 4];
                end
                if (CFG_BE[0])
                begin
                    next_mps = wr_mps;
                end
            end
            // capture only on the upstream port
            if (!up_sync)
            begin
                next_pwr_val = dcr_pkg::PWR_VAL_RST;
                next_pwr_scl = dcr_pkg::PWR_SCL_RST;
            end
            else if (PWR_MSG)
            begin
                next_pwr_val = PWR_MSG_VALUE;
                next_pwr_scl = PWR_MSG_SCALE;
            end
            if (CFG_RD)
            begin
                next_rvalid = 1'h1;
                if (CFG_ADDR == dcr_pkg::OFS_DEV_CAP)
                begin
                    next_rdata = cap_word;
                end
                else if (sel_ctl)
                begin
                    next_rdata = ctl_word;
                end
                else
                begin
                    next_rdata = 32'h0;
                end
            end
        end
        else
        begin
            next_rvalid = rvalid;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            mps_sup <= dcr_pkg::MPS_SUP_RST;
            rber <= dcr_pkg::RBER_RST;
            pwr_val <= dcr_pkg::PWR_VAL_RST;
            pwr_scl <= dcr_pkg::PWR_SCL_RST;
            err_en <= dcr_pkg::ERR_EN_RST;
            mps <= dcr_pkg::MPS_RST;
            rdata <= 32'h0;
            rvalid <= 1'h0;
        end
        else
        begin
            mps_sup <= next_mps_sup;
            rber <= next_rber;
            pwr_val <= next_pwr_val;
            pwr_scl <= next_pwr_scl;
            err_en <= next_err_en;
            mps <= next_mps;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign CFG_RDATA = rdata;
    assign CFG_RVALID = rvalid;
    assign ERR_REPORT_EN = err_en;
    assign MAX_PAYLOAD = mps;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    sequence s_ctl_write;
        CE && !PRELOAD && CFG_WR && sel_ctl && CFG_BE[0];
    endsequence

    chk_mps_clamp: assert property (@(posedge CLK) disable iff (RST)
        s_ctl_write |=> (mps <= mps_sup))
        else $error("Payload size above supported value.");
    chk_mps_store: assert property (@(posedge CLK) disable iff (RST)
        s_ctl_write ##0 (CFG_WDATA[7:5] <= mps_sup)
        |=> mps == $past(CFG_WDATA[7:5]))
        else $error("Payload size not stored.");
    chk_err_store: assert property (@(posedge CLK) disable iff (RST)
        s_ctl_write |=> err_en == $past(CFG_WDATA[3:0]))
        else $error("Error enables not stored.");
    chk_cap_zero: assert property (@(posedge CLK) disable iff (RST)
        CE && CFG_RD && CFG_ADDR == dcr_pkg::OFS_DEV_CAP
        |=> rdata[14:3] == 12'h0 && rdata[17:16] == 2'h0
        && rdata[31:28] == 4'h0)
        else $error("Hardwired bits read nonzero.");
    chk_ctl_zero: assert property (@(posedge CLK) disable iff (RST)
        CE && CFG_RD && sel_ctl |=> rdata[31:8] == 24'h0 && rdata[4] == 1'h0)
        else $error("Control zero bits read nonzero.");
    chk_pwr_down: assert property (@(posedge CLK) disable iff (RST)
        CE && !up_sync |=> pwr_val == 8'h0 && pwr_scl == 2'h0)
        else $error("Downstream port holds power limit.");
    chk_pwr_take: assert property (@(posedge CLK) disable iff (RST)
        CE && up_sync && PWR_MSG |=> pwr_val == $past(PWR_MSG_VALUE))
        else $error("Power limit not captured.");
    chk_cap_read: assert property (@(posedge CLK) disable iff (RST)
        CE && CFG_RD && CFG_ADDR == dcr_pkg::OFS_DEV_CAP
        |=> rvalid && rdata[2:0] == $past(mps_sup))
        else $error("Capability read wrong.");
endmodule

// [src/dcr_pkg.sv]
// Package with offsets, field positions and reset values of the register bank.
package dcr_pkg;
    localparam logic [7:0] OFS_DEV_CAP = 8'h6c;
    localparam logic [7:0] OFS_DEV_CTL = 8'h70;
    localparam int MPS_SUP_LSB = 0;
    localparam int RBER_BIT = 15;
    localparam int PWR_VAL_LSB = 18;
    localparam int PWR_SCL_LSB = 26;
    localparam int ERR_EN_LSB = 0;
    localparam int MPS_LSB = 5;
    localparam logic [2:0] MPS_SUP_RST = 3'h1;
    localparam logic [2:0] MPS_MAX_CODE = 3'h2;
    localparam logic [2:0] MPS_RST = 3'h0;
    localparam logic [3:0] ERR_EN_RST = 4'h0;
    localparam logic RBER_RST = 1'h1;
    localparam logic [7:0] PWR_VAL_RST = 8'h00;
    localparam logic [1:0] PWR_SCL_RST = 2'h0;
endpackage

// [src/dcr_sync.sv]
// Three-stage synchroniser that reports a level once stages two and three agree.
`timescale 1ns/1ps
module dcr_sync (
    input wire logic CLK,
    input wire logic RST,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_dout;

    always_comb
    begin
        next_stage = ce ? {stage[1:0], din} : stage;
        next_dout = dout;
        if (ce && stage[1] == stage[2])
        begin
            next_dout = stage[2];
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            stage <= 3'h0;
            dout <= 1'h0;
        end
        else
        begin
            stage <= next_stage;
            dout <= next_dout;
        end
    end
endmodule

// [sim/tb_top.sv]
// Self-checking testbench for the device capability and control registers.
`timescale 1ns/1ps
module tb_top;
    logic CLK = 0, RST = 1, CE = 1, UPSTREAM = 0, CFG_WR = 0, CFG_RD = 0;
    logic PWR_MSG = 0, PRELOAD = 0, PRELOAD_RBER = 0;
    logic [7:0] CFG_ADDR = 8'h00, PWR_MSG_VALUE = 8'h00;
    logic [31:0] CFG_WDATA = 32'h0, CFG_RDATA, rd_data;
    logic [3:0] CFG_BE = 4'h0, PRELOAD_ERR_EN = 4'h0, ERR_REPORT_EN;
    logic [1:0] PWR_MSG_SCALE = 2'h0;
    logic [2:0] PRELOAD_MPS_SUP = 3'h0, PRELOAD_MPS = 3'h0, MAX_PAYLOAD;
    logic CFG_RVALID;
    int err_total = 0, total_checks = 0;
    localparam logic [7:0] CAP = dcr_pkg::OFS_DEV_CAP;
    localparam logic [7:0] CTL = dcr_pkg::OFS_DEV_CTL;

    always #4 CLK = ~CLK;

    dcr_regs dcr_regs_inst (.CLK(CLK), .RST(RST), .CE(CE),
        .UPSTREAM(UPSTREAM), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
        .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA), .CFG_BE(CFG_BE),
        .PWR_MSG(PWR_MSG), .PWR_MSG_VALUE(PWR_MSG_VALUE),
        .PWR_MSG_SCALE(PWR_MSG_SCALE), .PRELOAD(PRELOAD),
        .PRELOAD_MPS_SUP(PRELOAD_MPS_SUP), .PRELOAD_RBER(PRELOAD_RBER),
        .PRELOAD_ERR_EN(PRELOAD_ERR_EN), .PRELOAD_MPS(PRELOAD_MPS),
        .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
        .ERR_REPORT_EN(ERR_REPORT_EN), .MAX_PAYLOAD(MAX_PAYLOAD));

    task automatic wrap_up();
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Expected capability word built from its fields.
    function automatic logic [31:0] cap_val(input logic [1:0] s,
        input logic [7:0] v, input logic r, input logic [2:0] m);
        return (32'(s) << dcr_pkg::PWR_SCL_LSB) |
            (32'(v) << dcr_pkg::PWR_VAL_LSB) |
            (32'(r) << dcr_pkg::RBER_BIT) | 32'(m);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        CFG_ADDR = a;
        CFG_WDATA = d;
        CFG_BE = be;
        CFG_WR = 1;
        @(negedge CLK);
        CFG_WR = 0;
        @(negedge CLK);
    endtask

    // A read answers one cycle later; the wait is bounded.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        int n = 0;
        CFG_ADDR = a;
        CFG_RD = 1;
        @(negedge CLK);
        CFG_RD = 0;
        while (CFG_RVALID !== 1'b1 && n < 4)
        begin
            @(negedge CLK);
            n++;
        end
        if (CFG_RVALID !== 1'b1)
        begin
            err_total++;
            $display("mismatch at %0t: no read answer", $time);
            wrap_up();
        end
        else
        begin
            chk(CFG_RDATA, exp);
            @(negedge CLK);
        end
    endtask

    task automatic t_reset();
        rd_chk(CAP, cap_val(2'h0, 8'h00, 1'b1, 3'h1));
        rd_chk(CTL, 32'h0);
        chk({28'h0, ERR_REPORT_EN}, 32'h0);
        chk({29'h0, MAX_PAYLOAD}, 32'h0);
    endtask

    task automatic t_ctl();
        wr(CTL, 32'hffffffff, 4'hf);
        rd_chk(CTL, 32'h0000002f);
        chk({28'h0, ERR_REPORT_EN}, 32'hf);
        chk({29'h0, MAX_PAYLOAD}, 32'h1);
        wr(CTL, 32'h0000ff00, 4'hf);
        rd_chk(CTL, 32'h0);
        wr(CTL, 32'h0000002a, 4'he);
        rd_chk(CTL, 32'h0);
        wr(CTL, 32'h00000020, 4'h1);
        rd_chk(CTL, 32'h00000020);
        wr(CTL, 32'h00000040, 4'h1);
        rd_chk(CTL, 32'h00000020);
    endtask

    task automatic t_cap_ro();
        wr(CAP, 32'hffffffff, 4'hf);
        rd_chk(CAP, cap_val(2'h0, 8'h00, 1'b1, 3'h1));
        wr(8'h74, 32'hffffffff, 4'hf);
        rd_chk(8'h74, 32'h0);
        rd_chk(CTL, 32'h00000020);
    endtask

    task automatic msg(input logic [7:0] v, input logic [1:0] s);
        PWR_MSG_VALUE = v;
        PWR_MSG_SCALE = s;
        PWR_MSG = 1;
        @(negedge CLK);
        PWR_MSG = 0;
    endtask

    task automatic t_power();
        msg(8'h5a, 2'h2);
        rd_chk(CAP, cap_val(2'h0, 8'h00, 1'b1, 3'h1));
        UPSTREAM = 1;
        repeat (8) @(negedge CLK);
        msg(8'ha5, 2'h3);
        rd_chk(CAP, cap_val(2'h3, 8'ha5, 1'b1, 3'h1));
        UPSTREAM = 0;
        repeat (8) @(negedge CLK);
        rd_chk(CAP, cap_val(2'h0, 8'h00, 1'b1, 3'h1));
    endtask

    task automatic t_preload();
        PRELOAD_MPS_SUP = 3'h2;
        PRELOAD_ERR_EN = 4'h5;
        PRELOAD_MPS = 3'h2;
        PRELOAD = 1;
        @(negedge CLK);
        PRELOAD = 0;
        rd_chk(CAP, cap_val(2'h0, 8'h00, 1'b0, 3'h2));
        rd_chk(CTL, 32'h00000045);
        wr(CTL, 32'h000000e0, 4'h1);
        rd_chk(CTL, 32'h00000040);
        chk({29'h0, MAX_PAYLOAD}, 32'h2);
    endtask

    // Clock enable low freezes the bank; a mid-run reset restores defaults.
    task automatic t_freeze();
        CE = 0;
        wr(CTL, 32'h0000000f, 4'h1);
        CFG_ADDR = CTL;
        CFG_RD = 1;
        @(negedge CLK);
        CFG_RD = 0;
        chk({31'h0, CFG_RVALID}, 32'h0);
        chk({28'h0, ERR_REPORT_EN}, 32'h0);
        CE = 1;
        @(negedge CLK);
        rd_chk(CTL, 32'h00000040);
        RST = 1;
        @(negedge CLK);
        RST = 0;
        rd_chk(CAP, cap_val(2'h0, 8'h00, 1'b1, 3'h1));
        rd_chk(CTL, 32'h0);
    endtask

    initial
    begin
        repeat (5) @(negedge CLK);
        RST = 0;
        t_reset();
        t_ctl();
        t_cap_ro();
        t_power();
        t_preload();
        t_freeze();
        wrap_up();
    end
endmodule
